// [psg_pkg.sv]
package psg_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned PWM_PINS   = 6;
    localparam int unsigned FAULT_PINS = 7;
    localparam int unsigned FAULT_NUM  = 4;
    localparam int unsigned SENSE_NUM  = 3;
    localparam int unsigned REG_W      = 8;
    localparam int unsigned IDX_W      = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned STRB_W     = 4;
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned IDX_LSB    = 2;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_PWM_PORT_DATA       = 8'h18;
    localparam logic [IDX_W-1:0] IDX_PWM_PORT_PIN_LEVEL  = 8'h19;
    localparam logic [IDX_W-1:0] IDX_PWM_PORT_DIRECTION  = 8'h1A;
    localparam logic [IDX_W-1:0] IDX_PWM_PORT_DRIVE      = 8'h1B;
    localparam logic [IDX_W-1:0] IDX_PWM_PORT_PULL_EN    = 8'h1C;
    localparam logic [IDX_W-1:0] IDX_PWM_PORT_POLARITY   = 8'h1D;
    localparam logic [IDX_W-1:0] IDX_FAULT_PORT_DATA     = 8'h20;
    localparam logic [IDX_W-1:0] IDX_FAULT_PORT_PIN_LVL  = 8'h21;
    localparam logic [IDX_W-1:0] IDX_FAULT_PORT_DIR      = 8'h22;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PWM_PINS-1:0]   PWM_RST   = 6'h00;
    localparam logic [FAULT_PINS-1:0] FAULT_RST = 7'h00;

    // ------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [psg_regbus_if.sv]
`timescale 1ns/1ps
interface psg_regbus_if;
    import psg_pkg::*;

    logic                   wr_en;
    logic [IDX_W-1:0]       wr_idx;
    logic [DATA_W-1:0]      wr_data;
    logic                   wr_byte0;
    logic                   wr_ok;
    logic                   rd_en;
    logic [IDX_W-1:0]       rd_idx;
    logic [DATA_W-1:0]      rd_data;
    logic                   rd_ok;

    modport slave_side (
        output wr_en,
        output wr_idx,
        output wr_data,
        output wr_byte0,
        input  wr_ok,
        output rd_en,
        output rd_idx,
        input  rd_data,
        input  rd_ok
    );

    modport reg_side (
        input  wr_en,
        input  wr_idx,
        input  wr_data,
        input  wr_byte0,
        output wr_ok,
        input  rd_en,
        input  rd_idx,
        output rd_data,
        output rd_ok
    );
endinterface

// [psg_axil_slave.sv]
`timescale 1ns/1ps
module psg_axil_slave
    import psg_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   s_axil_awaddr,
    input  wire logic                s_axil_awvalid,
    output logic                     s_axil_awready,
    input  wire logic [DATA_W-1:0]   s_axil_wdata,
    input  wire logic [STRB_W-1:0]   s_axil_wstrb,
    input  wire logic                s_axil_wvalid,
    output logic                     s_axil_wready,
    output logic [1:0]               s_axil_bresp,
    output logic                     s_axil_bvalid,
    input  wire logic                s_axil_bready,
    input  wire logic [ADDR_W-1:0]   s_axil_araddr,
    input  wire logic                s_axil_arvalid,
    output logic                     s_axil_arready,
    output logic [DATA_W-1:0]        s_axil_rdata,
    output logic [1:0]               s_axil_rresp,
    output logic                     s_axil_rvalid,
    input  wire logic                s_axil_rready,
    psg_regbus_if.slave_side         rb
);

    logic                aw_held_reg;
    logic                w_held_reg;
    logic                ar_held_reg;
    logic [IDX_W-1:0]    aw_idx_reg;
    logic [IDX_W-1:0]    ar_idx_reg;
    logic [DATA_W-1:0]   w_data_reg;
    logic                w_byte0_reg;

    // ------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------
    // Address and data are taken in either order, then committed together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            aw_idx_reg     <= '0;
            w_data_reg     <= '0;
            w_byte0_reg    <= 1'b0;
            s_axil_awready <= 1'b0;
            s_axil_wready  <= 1'b0;
            s_axil_bvalid  <= 1'b0;
            s_axil_bresp   <= RESP_OKAY;
        end else begin
            s_axil_awready <= !aw_held_reg && !s_axil_bvalid
                              && !(s_axil_awvalid && s_axil_awready);
            s_axil_wready  <= !w_held_reg && !s_axil_bvalid
                              && !(s_axil_wvalid && s_axil_wready);
            if (s_axil_awvalid && s_axil_awready) begin
                aw_held_reg <= 1'b1;
                aw_idx_reg  <= s_axil_awaddr[IDX_LSB +: IDX_W];
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_held_reg  <= 1'b1;
                w_data_reg  <= s_axil_wdata;
                w_byte0_reg <= s_axil_wstrb[0];
            end
            if (rb.wr_en) begin
                aw_held_reg   <= 1'b0;
                w_held_reg    <= 1'b0;
                s_axil_bvalid <= 1'b1;
                s_axil_bresp  <= rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    assign rb.wr_en    = aw_held_reg && w_held_reg && !s_axil_bvalid;
    assign rb.wr_idx   = aw_idx_reg;
    assign rb.wr_data  = w_data_reg;
    assign rb.wr_byte0 = w_byte0_reg;

    // ------------------------------------------------------------
    // Read channels
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_held_reg    <= 1'b0;
            ar_idx_reg     <= '0;
            s_axil_arready <= 1'b0;
            s_axil_rvalid  <= 1'b0;
            s_axil_rdata   <= '0;
            s_axil_rresp   <= RESP_OKAY;
        end else begin
            s_axil_arready <= !ar_held_reg && !s_axil_rvalid
                              && !(s_axil_arvalid && s_axil_arready);
            if (s_axil_arvalid && s_axil_arready) begin
                ar_held_reg <= 1'b1;
                ar_idx_reg  <= s_axil_araddr[IDX_LSB +: IDX_W];
            end
            if (rb.rd_en) begin
                ar_held_reg   <= 1'b0;
                s_axil_rvalid <= 1'b1;
                s_axil_rdata  <= rb.rd_data;
                s_axil_rresp  <= rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axil_rvalid && s_axil_rready) begin
                s_axil_rvalid <= 1'b0;
            end
        end
    end

    assign rb.rd_en  = ar_held_reg && !s_axil_rvalid;
    assign rb.rd_idx = ar_idx_reg;

endmodule

// [psg_gpio_ports.sv]
`timescale 1ns/1ps
// Behaviour
// - In reset every pin of the PWM port is an undriven input with no pull.
// - In reset every pin of the fault port is an undriven input.
// - A data register read gives the stored bit where direction is 1, else the pin level.
// - The pin level registers always show the pins and ignore writes.
// - Data, direction, drive, pull enable and polarity registers are read and written anytime.
// - An enabled PWM channel drives its pin as an output whatever the direction bit.
// - PWM channels 5 to 0 appear on PWM port pins 5 to 0.
// - When a PWM channel or function is disabled the direction bit rules its pin again.
// - An enabled fault or current sense function forces its pin to input.
// - Fault port pins 3 to 0 feed the fault inputs and pins 6 to 4 the current sense inputs.
// - The PWM port direction register controls six pins, 0 input and 1 output.
// - The fault port direction register controls seven pins, 0 input and 1 output.
// - A drive bit of 1 selects reduced drive on an output, 0 full drive, no effect on inputs.
// - A pull enable bit of 1 turns the pull device on, 0 off, no effect on outputs.
// - Polarity 0 selects pull-up and 1 pull-down, only for direction 0 with pull enabled.
module psg_gpio_ports
    import psg_pkg::*;
#(
    parameter int unsigned N_PWM   = PWM_PINS,
    parameter int unsigned N_FAULT = FAULT_PINS
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   s_axil_awaddr,
    input  wire logic                s_axil_awvalid,
    output logic                     s_axil_awready,
    input  wire logic [DATA_W-1:0]   s_axil_wdata,
    input  wire logic [STRB_W-1:0]   s_axil_wstrb,
    input  wire logic                s_axil_wvalid,
    output logic                     s_axil_wready,
    output logic [1:0]               s_axil_bresp,
    output logic                     s_axil_bvalid,
    input  wire logic                s_axil_bready,
    input  wire logic [ADDR_W-1:0]   s_axil_araddr,
    input  wire logic                s_axil_arvalid,
    output logic                     s_axil_arready,
    output logic [DATA_W-1:0]        s_axil_rdata,
    output logic [1:0]               s_axil_rresp,
    output logic                     s_axil_rvalid,
    input  wire logic                s_axil_rready,
    input  wire logic [N_PWM-1:0]    pwm_port_pins_in,
    output logic      [N_PWM-1:0]    pwm_port_pins_out,
    output logic      [N_PWM-1:0]    pwm_port_pins_oe,
    output logic      [N_PWM-1:0]    pwm_port_drive_reduced,
    output logic      [N_PWM-1:0]    pwm_port_pull_on,
    output logic      [N_PWM-1:0]    pwm_port_pull_down,
    input  wire logic [N_FAULT-1:0]  fault_port_pins_in,
    output logic      [N_FAULT-1:0]  fault_port_pins_out,
    output logic      [N_FAULT-1:0]  fault_port_pins_oe,
    input  wire logic [N_PWM-1:0]    pwm_channel_enable,
    input  wire logic [N_PWM-1:0]    pwm_channel_outputs,
    input  wire logic [N_FAULT-1:0]  fault_function_enable,
    output logic      [FAULT_NUM-1:0] fault_inputs,
    output logic      [SENSE_NUM-1:0] current_sense_inputs
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Output pins read back the latch, inputs read the synchronised pin
    function automatic logic [REG_W-1:0] port_read(
        input logic [REG_W-1:0] dir,
        input logic [REG_W-1:0] stored,
        input logic [REG_W-1:0] pin
    );
        port_read = (dir & stored) | (~dir & pin);
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
        widen = {{(DATA_W-REG_W){1'b0}}, v};
    endfunction

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    psg_regbus_if rb ();

    psg_axil_slave u_slave (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .s_axil_awaddr  (s_axil_awaddr),
        .s_axil_awvalid (s_axil_awvalid),
        .s_axil_awready (s_axil_awready),
        .s_axil_wdata   (s_axil_wdata),
        .s_axil_wstrb   (s_axil_wstrb),
        .s_axil_wvalid  (s_axil_wvalid),
        .s_axil_wready  (s_axil_wready),
        .s_axil_bresp   (s_axil_bresp),
        .s_axil_bvalid  (s_axil_bvalid),
        .s_axil_bready  (s_axil_bready),
        .s_axil_araddr  (s_axil_araddr),
        .s_axil_arvalid (s_axil_arvalid),
        .s_axil_arready (s_axil_arready),
        .s_axil_rdata   (s_axil_rdata),
        .s_axil_rresp   (s_axil_rresp),
        .s_axil_rvalid  (s_axil_rvalid),
        .s_axil_rready  (s_axil_rready),
        .rb             (rb.slave_side)
    );

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [N_PWM-1:0]   pwm_data_reg;
    logic [N_PWM-1:0]   pwm_dir_reg;
    logic [N_PWM-1:0]   pwm_drive_reg;
    logic [N_PWM-1:0]   pwm_pull_en_reg;
    logic [N_PWM-1:0]   pwm_pol_reg;
    logic [N_FAULT-1:0] fault_data_reg;
    logic [N_FAULT-1:0] fault_dir_reg;

    logic [N_PWM-1:0]   pwm_meta_reg;
    logic [N_PWM-1:0]   pwm_sync_reg;
    logic [N_FAULT-1:0] fault_meta_reg;
    logic [N_FAULT-1:0] fault_sync_reg;

    logic               wr_byte;
    logic [REG_W-1:0]   wr_val;

    assign wr_byte = rb.wr_en && rb.wr_byte0;
    assign wr_val  = rb.wr_data[REG_W-1:0];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_meta_reg   <= '0;
            pwm_sync_reg   <= '0;
            fault_meta_reg <= '0;
            fault_sync_reg <= '0;
        end else begin
            pwm_meta_reg   <= pwm_port_pins_in;
            pwm_sync_reg   <= pwm_meta_reg;
            fault_meta_reg <= fault_port_pins_in;
            fault_sync_reg <= fault_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // PWM port registers
    // ------------------------------------------------------------
    // written anytime
    // bits above the port stay unstored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_data_reg    <= PWM_RST;
            pwm_dir_reg     <= PWM_RST;
            pwm_drive_reg   <= PWM_RST;
            pwm_pull_en_reg <= PWM_RST;
            pwm_pol_reg     <= PWM_RST;
        end else if (wr_byte) begin
            unique case (rb.wr_idx)
                IDX_PWM_PORT_DATA:      pwm_data_reg    <= wr_val[N_PWM-1:0];
                IDX_PWM_PORT_DIRECTION: pwm_dir_reg     <= wr_val[N_PWM-1:0];
                IDX_PWM_PORT_DRIVE:     pwm_drive_reg   <= wr_val[N_PWM-1:0];
                IDX_PWM_PORT_PULL_EN:   pwm_pull_en_reg <= wr_val[N_PWM-1:0];
                IDX_PWM_PORT_POLARITY:  pwm_pol_reg     <= wr_val[N_PWM-1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Fault port registers
    // ------------------------------------------------------------
    // seven direction bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_data_reg <= FAULT_RST;
            fault_dir_reg  <= FAULT_RST;
        end else if (wr_byte) begin
            unique case (rb.wr_idx)
                IDX_FAULT_PORT_DATA: fault_data_reg <= wr_val[N_FAULT-1:0];
                IDX_FAULT_PORT_DIR:  fault_dir_reg  <= wr_val[N_FAULT-1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address decode and read mux
    // ------------------------------------------------------------
    logic [REG_W-1:0] pwm_dir_w;
    logic [REG_W-1:0] pwm_data_w;
    logic [REG_W-1:0] pwm_pin_w;
    logic [REG_W-1:0] fault_dir_w;
    logic [REG_W-1:0] fault_data_w;
    logic [REG_W-1:0] fault_pin_w;

    assign pwm_dir_w    = REG_W'(pwm_dir_reg);
    assign pwm_data_w   = REG_W'(pwm_data_reg);
    assign pwm_pin_w    = REG_W'(pwm_sync_reg);
    assign fault_dir_w  = REG_W'(fault_dir_reg);
    assign fault_data_w = REG_W'(fault_data_reg);
    assign fault_pin_w  = REG_W'(fault_sync_reg);

    // Pin level registers are mapped for writes too, but writes change nothing
    always_comb begin
        unique case (rb.wr_idx)
            IDX_PWM_PORT_DATA, IDX_PWM_PORT_PIN_LEVEL, IDX_PWM_PORT_DIRECTION,
            IDX_PWM_PORT_DRIVE, IDX_PWM_PORT_PULL_EN, IDX_PWM_PORT_POLARITY,
            IDX_FAULT_PORT_DATA, IDX_FAULT_PORT_PIN_LVL, IDX_FAULT_PORT_DIR:
                rb.wr_ok = 1'b1;
            default:
                rb.wr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rb.rd_ok   = 1'b1;
        rb.rd_data = '0;
        unique case (rb.rd_idx)
            IDX_PWM_PORT_DATA:
                rb.rd_data = widen(port_read(pwm_dir_w, pwm_data_w, pwm_pin_w));
            IDX_PWM_PORT_PIN_LEVEL:
                rb.rd_data = widen(pwm_pin_w);
            IDX_PWM_PORT_DIRECTION:
                rb.rd_data = widen(pwm_dir_w);
            IDX_PWM_PORT_DRIVE:
                rb.rd_data = widen(REG_W'(pwm_drive_reg));
            IDX_PWM_PORT_PULL_EN:
                rb.rd_data = widen(REG_W'(pwm_pull_en_reg));
            IDX_PWM_PORT_POLARITY:
                rb.rd_data = widen(REG_W'(pwm_pol_reg));
            IDX_FAULT_PORT_DATA:
                rb.rd_data = widen(port_read(fault_dir_w, fault_data_w, fault_pin_w));
            IDX_FAULT_PORT_PIN_LVL:
                rb.rd_data = widen(fault_pin_w);
            IDX_FAULT_PORT_DIR:
                rb.rd_data = widen(fault_dir_w);
            default:
                rb.rd_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // PWM port pad control
    // ------------------------------------------------------------
    logic [N_PWM-1:0] pwm_oe_next;
    logic [N_PWM-1:0] pwm_out_next;

    // direction bit rules when channel off
    assign pwm_oe_next  = pwm_channel_enable | pwm_dir_reg;
    // stored bit drives a GPIO output
    assign pwm_out_next = (pwm_channel_enable & pwm_channel_outputs)
                        | (~pwm_channel_enable & pwm_data_reg);

    // Pads follow one cycle late so every output leaves a flip-flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_port_pins_oe       <= '0;
            pwm_port_pins_out      <= '0;
            pwm_port_drive_reduced <= '0;
            pwm_port_pull_on       <= '0;
            pwm_port_pull_down     <= '0;
        end else begin
            pwm_port_pins_oe       <= pwm_oe_next;
            pwm_port_pins_out      <= pwm_out_next;
            pwm_port_drive_reduced <= pwm_drive_reg & pwm_oe_next;
            pwm_port_pull_on       <= pwm_pull_en_reg & ~pwm_oe_next;
            // polarity when input with pull enabled
            pwm_port_pull_down     <= pwm_pol_reg & pwm_pull_en_reg & ~pwm_oe_next;
        end
    end

    // ------------------------------------------------------------
    // Fault port pad control
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_port_pins_oe  <= '0;
            fault_port_pins_out <= '0;
        end else begin
            // direction bit rules when function off
            fault_port_pins_oe  <= ~fault_function_enable & fault_dir_reg;
            // stored bit drives a GPIO output
            fault_port_pins_out <= fault_data_reg;
        end
    end

    // ------------------------------------------------------------
    // Feeds to the PWM module
    // ------------------------------------------------------------
    // Levels pass even with the function off; the PWM module masks them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_inputs         <= '0;
            current_sense_inputs <= '0;
        end else begin
            // pins 3..0 fault, 6..4 current sense
            fault_inputs         <= fault_sync_reg[FAULT_NUM-1:0];
            current_sense_inputs <= fault_sync_reg[FAULT_NUM +: SENSE_NUM];
        end
    end

endmodule

// [psg_gpio_sva.sv]
`timescale 1ns/1ps
module psg_gpio_sva
    import psg_pkg::*;
#(
    parameter int unsigned N_PWM   = PWM_PINS,
    parameter int unsigned N_FAULT = FAULT_PINS
) (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic [N_PWM-1:0]     pwm_port_pins_oe,
    input wire logic [N_PWM-1:0]     pwm_port_pins_out,
    input wire logic [N_PWM-1:0]     pwm_port_drive_reduced,
    input wire logic [N_PWM-1:0]     pwm_port_pull_on,
    input wire logic [N_PWM-1:0]     pwm_channel_enable,
    input wire logic [N_PWM-1:0]     pwm_channel_outputs,
    input wire logic [N_FAULT-1:0]   fault_port_pins_oe,
    input wire logic [N_FAULT-1:0]   fault_port_pins_in,
    input wire logic [N_FAULT-1:0]   fault_function_enable,
    input wire logic [FAULT_NUM-1:0] fault_inputs,
    input wire logic [SENSE_NUM-1:0] current_sense_inputs
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rst_pwm_a: assert property (disable iff (1'b0)
        !aresetn |=> (pwm_port_pins_oe | pwm_port_pull_on) == '0) else $error("PWM pins in reset");
    rst_fault_a: assert property (disable iff (1'b0)
        !aresetn |=> fault_port_pins_oe == '0) else $error("Fault pins driven in reset");
    pwm_own_a: assert property (aresetn |=>
        (~pwm_port_pins_oe & $past(pwm_channel_enable)) == '0) else $error("Channel pin not out");
    pwm_val_a: assert property (aresetn |=> ((pwm_port_pins_out ^
        $past(pwm_channel_outputs)) & $past(pwm_channel_enable)) == '0) else $error("Channel value");
    fault_in_a: assert property (aresetn |=>
        (fault_port_pins_oe & $past(fault_function_enable)) == '0) else $error("Fault pin driven");
    fault_route_a: assert property ((aresetn && $stable(fault_port_pins_in))[*4] |->
        {current_sense_inputs, fault_inputs} == fault_port_pins_in) else $error("Fault routing");
    drive_gate_a: assert property (
        (pwm_port_drive_reduced & ~pwm_port_pins_oe) == '0) else $error("Reduced drive on input");
    pull_gate_a: assert property (
        (pwm_port_pull_on & pwm_port_pins_oe) == '0) else $error("Pull on an output");
    cover property (pwm_channel_enable != '0 && pwm_port_pins_oe != '0);
    cover property (fault_function_enable != '0 && fault_port_pins_oe != '0);
    cover property (pwm_port_pull_on != '0);
endmodule
bind psg_gpio_ports psg_gpio_sva #(.N_PWM(N_PWM), .N_FAULT(N_FAULT)) i_sva (.*);

// [psg_pad_model.sv]
`timescale 1ns/1ps
module psg_pad_model #(
    parameter int unsigned N = 6
) (
    input  wire logic         aclk,
    input  wire logic [N-1:0] pins_out,
    input  wire logic [N-1:0] pins_oe,
    input  wire logic [N-1:0] pull_on,
    input  wire logic [N-1:0] pull_down,
    input  wire logic [N-1:0] ext_en,
    input  wire logic [N-1:0] ext_val,
    output logic      [N-1:0] pins_level
);
    logic [N-1:0] float_reg = '0;
    // A floating pad wanders, so no one may rely on its last value
    always @(posedge aclk) float_reg <= ~float_reg;
    assign pins_level = (pins_oe & pins_out) | (~pins_oe & ext_en & ext_val)
        | (~pins_oe & ~ext_en & ((pull_on & ~pull_down) | (~pull_on & float_reg)));
endmodule

// [tb_pwm_shared_gpio_ports.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb_pwm_shared_gpio_ports;
    import psg_pkg::*;
    logic              aclk = 1'b0, aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axil_awaddr = '0, s_axil_araddr = '0;
    logic [DATA_W-1:0] s_axil_wdata = '0, s_axil_rdata;
    logic [STRB_W-1:0] s_axil_wstrb = '0;
    logic [1:0]        s_axil_bresp, s_axil_rresp;
    logic              s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
    logic              s_axil_arvalid = 0, s_axil_rready = 0;
    logic              s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [5:0]        pwm_port_pins_in, pwm_port_pins_out, pwm_port_pins_oe;
    logic [5:0]        pwm_port_drive_reduced, pwm_port_pull_on, pwm_port_pull_down;
    logic [5:0]        pwm_channel_enable = '0, pwm_channel_outputs = '0;
    logic [5:0]        p_ext_en = 6'h3F, p_ext_val = 6'h20;
    logic [6:0]        fault_port_pins_in, fault_port_pins_out, fault_port_pins_oe;
    logic [6:0]        fault_function_enable = '0, q_ext_en = 7'h7F, q_ext_val = 7'h00;
    logic [3:0]        fault_inputs;
    logic [2:0]        current_sense_inputs;
    int                fail_count = 0, samples_checked = 0, cycles = 0;
    logic [7:0]        idx_tab [5] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h22};
    psg_gpio_ports i_dut (.*);
    psg_pad_model #(.N(6)) i_ppad (.aclk, .pins_out(pwm_port_pins_out), .pins_oe(pwm_port_pins_oe),
        .pull_on(pwm_port_pull_on), .pull_down(pwm_port_pull_down), .ext_en(p_ext_en),
        .ext_val(p_ext_val), .pins_level(pwm_port_pins_in));
    psg_pad_model #(.N(7)) i_qpad (.aclk, .pins_out(fault_port_pins_out),
        .pins_oe(fault_port_pins_oe), .pull_on(7'h00), .pull_down(7'h00), .ext_en(q_ext_en),
        .ext_val(q_ext_val), .pins_level(fault_port_pins_in));
    always #5 aclk = ~aclk;
    task automatic wrap_up();
        $display("Counts: %0d checked, %0d failed", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axil_awaddr <= {2'b00, idx, 2'b00};
        s_axil_wdata <= {24'h0, d};
        s_axil_wstrb <= 4'hF;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
            if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
        end while (s_axil_bvalid !== 1'b1);
        s_axil_bready <= 1'b0;
        `CHK(s_axil_bresp, er)
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axil_araddr <= {2'b00, idx, 2'b00};
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
        end while (s_axil_rvalid !== 1'b1);
        s_axil_rready <= 1'b0;
        `CHK(s_axil_rdata, {24'h0, e})
        `CHK(s_axil_rresp, er)
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK(pwm_port_pins_oe, 6'h00)
        `CHK(fault_port_pins_oe, 7'h00)
        rd(8'h1A, 8'h00, RESP_OKAY);
        rd(8'h18, 8'h20, RESP_OKAY);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(idx_tab[i], 8'hFF, RESP_OKAY);
            rd(idx_tab[i], (i == 4) ? 8'h7F : 8'h3F, RESP_OKAY);
        end
        `CHK(pwm_port_pins_oe, 6'h3F)
        `CHK(fault_port_pins_oe, 7'h7F)
        $display("test registers done");
        wr(8'h18, 8'hD5, RESP_OKAY);
        rd(8'h18, 8'h15, RESP_OKAY);
        `CHK(pwm_port_pins_out, 6'h15)
        wr(8'h19, 8'h00, RESP_OKAY);
        rd(8'h19, 8'h15, RESP_OKAY);
        wr(8'h20, 8'hD5, RESP_OKAY);
        rd(8'h20, 8'h55, RESP_OKAY);
        `CHK(fault_port_pins_out, 7'h55)
        $display("test data done");
        p_ext_en <= 6'h2F;
        wr(8'h1A, 8'h0F, RESP_OKAY);
        rd(8'h18, 8'h25, RESP_OKAY);
        `CHK(pwm_port_drive_reduced, 6'h0F)
        `CHK(pwm_port_pull_on, 6'h30)
        `CHK(pwm_port_pull_down & pwm_port_pull_on, 6'h30)
        wr(8'h1D, 8'h00, RESP_OKAY);
        rd(8'h19, 8'h35, RESP_OKAY);
        `CHK(pwm_port_pull_down & pwm_port_pull_on, 6'h00)
        $display("test pads done");
        pwm_channel_enable <= 6'h30;
        pwm_channel_outputs <= 6'h10;
        repeat (3) @(posedge aclk);
        `CHK(pwm_port_pins_oe, 6'h3F)
        `CHK(pwm_port_pins_out, 6'h15)
        `CHK(pwm_port_pull_on, 6'h00)
        pwm_channel_enable <= 6'h00;
        repeat (3) @(posedge aclk);
        `CHK(pwm_port_pins_oe, 6'h0F)
        $display("test channels done");
        fault_function_enable <= 7'h0F;
        q_ext_val <= 7'h0A;
        repeat (6) @(posedge aclk);
        `CHK(fault_port_pins_oe, 7'h70)
        `CHK(fault_inputs, 4'hA)
        `CHK(current_sense_inputs, 3'h5)
        rd(8'h21, 8'h5A, RESP_OKAY);
        fault_function_enable <= 7'h00;
        repeat (3) @(posedge aclk);
        `CHK(fault_port_pins_oe, 7'h7F)
        $display("test faults done");
        wr(8'h40, 8'hFF, RESP_SLVERR);
        rd(8'h40, 8'h00, RESP_SLVERR);
        $display("test unmapped done");
        wrap_up();
    end
endmodule
